/* File: core/cmsd_defs.vh */
/*
 * constants for the memory space decoder: program vector layout,
 * data space region bounds, step sizes and operation codes.
 * assumes inclusion by the decoder only; definitions only.
 */
// Contract
// R1: 24-bit program location read as even lower word, odd upper word, top byte zero.
// R2: program counter stays even, steps forward or back by two.
// R3: program 0x00000 to 0x000200 reserved for vectors; start at reset vector.
// R4: reset fetches jump at 0x000000; jump target read from 0x000002.
// R5: vector tables at 0x000004-0x0000FF and 0x000100-0x0001FF.
// R6: reads and writes form their addresses in separate generators.
// R7: data effective address is 16 bits, byte granular, 64 Kbytes.
// R8: address bit 15 low hits data memory, high hits visibility window.
// R9: reads outside implemented data memory return all zeros.
// R10: word low byte at even address, high byte at odd address.
// R11: post-modified pointer steps by 1 for bytes, 2 for words.
// R12: byte read fetches word, bit 0 selects byte, placed on low lane.
// R13: shared word decode, separate lane write enables; byte write hits one lane.
// R14: odd-address word access not performed; raises address error trap.
// R15: misaligned read completes; misaligned write suppressed; trap follows.
// R16: byte load changes working register low byte only.
// R17: sign-extend 8 to 16 bits; zero-extend clears high byte.
// R18: data 0x0000-0x07FF decodes to control registers.
// R19: unused control register addresses read zero.
// R20: 0x0000-0x1FFF reachable through 13-bit direct address field.
// R21: whole space reachable by 16-bit direct field or pointer register.
// R22: 0x0800-0x0BFF X RAM, 0x0C00-0x0FFF Y RAM, unimplemented above.
`ifndef CMSD_DEFS_VH
`define CMSD_DEFS_VH
`define CMSD_RESET_VEC   24'h000000
`define CMSD_JUMP_TGT    24'h000002
`define CMSD_VEC_END     24'h000200
`define CMSD_IVT1_LO     24'h000004
`define CMSD_IVT1_HI     24'h0000FF
`define CMSD_IVT2_LO     24'h000100
`define CMSD_IVT2_HI     24'h0001FF
`define CMSD_PC_STEP     24'h000002
`define CMSD_SFR_HI      16'h07FF
`define CMSD_XRAM_LO     16'h0800
`define CMSD_XRAM_HI     16'h0BFF
`define CMSD_YRAM_LO     16'h0C00
`define CMSD_YRAM_HI     16'h0FFF
`define CMSD_PSV_BIT     15
`define CMSD_STEP_BYTE   16'h0001
`define CMSD_STEP_WORD   16'h0002
`define CMSD_MODE_NEAR   2'h0
`define CMSD_MODE_DIRECT 2'h1
`define CMSD_MODE_PTR    2'h2
`define CMSD_OP_WORD     2'h0
`define CMSD_OP_BYTE     2'h1
`define CMSD_OP_SEXT     2'h2
`define CMSD_OP_ZEXT     2'h3
`define CMSD_VT_NONE     2'h0
`define CMSD_VT_RESET    2'h1
`define CMSD_VT_PRIMARY  2'h2
`define CMSD_VT_ALT      2'h3
`endif

/* File: core/cmsd_top.v */
/*
 * memory space decoder: program counter and vector boot, program word
 * layout, read and write address generators with region decode, lane
 * steering, alignment trap, pointer step and working register byte merge.
 * assumes memories answer combinationally to the registered addresses.
 */
`include "cmsd_defs.vh"
module cmsd_top (
  input  wire        i_clk,
  input  wire        i_srst,
  input  wire        i_pc_adv,
  input  wire        i_pc_ret,
  input  wire        i_pc_load,
  input  wire [23:0] i_pc_target,
  input  wire [23:0] i_prog_loc,
  input  wire [23:0] i_tbl_addr,
  input  wire [23:0] i_tbl_loc,
  input  wire        i_rd_req,
  input  wire        i_rd_byte,
  input  wire [1:0]  i_rd_mode,
  input  wire [12:0] i_rd_near,
  input  wire [15:0] i_rd_direct,
  input  wire [15:0] i_rd_ptr,
  input  wire        i_wr_req,
  input  wire        i_wr_byte,
  input  wire [1:0]  i_wr_mode,
  input  wire [12:0] i_wr_near,
  input  wire [15:0] i_wr_direct,
  input  wire [15:0] i_wr_ptr,
  input  wire [15:0] i_wr_data,
  input  wire [15:0] i_ram_rdata,
  input  wire [15:0] i_sfr_rdata,
  input  wire        i_sfr_hit,
  input  wire [15:0] i_psv_rdata,
  input  wire        i_ptr_step,
  input  wire [15:0] i_ptr_in,
  input  wire        i_ptr_byte,
  input  wire        i_ptr_dec,
  input  wire        i_wreg_op_en,
  input  wire [1:0]  i_wreg_op,
  input  wire [15:0] i_wreg_old,
  input  wire [15:0] i_wreg_src,
  output reg  [23:0] o_program_counter,
  output reg         o_boot_done,
  output reg  [1:0]  o_pc_vec_table,
  output reg  [15:0] o_tbl_word,
  output reg  [14:0] o_rd_word_addr,
  output reg         o_rd_sel_sfr,
  output reg         o_rd_sel_xram,
  output reg         o_rd_sel_yram,
  output reg         o_rd_sel_psv,
  output reg  [15:0] o_rd_data,
  output reg         o_rd_valid,
  output reg  [14:0] o_wr_word_addr,
  output reg         o_wr_sel_sfr,
  output reg         o_wr_sel_xram,
  output reg         o_wr_sel_yram,
  output reg  [1:0]  o_wr_lane_en,
  output reg  [15:0] o_wr_lane_data,
  output reg         o_addr_error_trap,
  output reg  [15:0] o_ptr_out,
  output reg  [15:0] o_wreg_new,
  output reg         o_wreg_valid
);

  localparam [1:0] ST_FETCH_JUMP = 2'h0;
  localparam [1:0] ST_FETCH_TGT  = 2'h1;
  localparam [1:0] ST_RUN        = 2'h2;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [23:0] pc_nxt;
  reg         rd_pend_r;
  reg         rd_byte_r;
  reg         rd_lane_r;
  reg         rd_bad_r;
  wire [15:0] rd_ea;
  wire [15:0] wr_ea;
  reg  [15:0] rd_word;
  reg  [15:0] rd_nxt;
  reg  [15:0] wreg_nxt;
  wire        rd_misalign;
  wire        wr_misalign;
  wire [1:0]  wr_lane_nxt;
  wire [15:0] wr_data_nxt;

  // one generator per direction so read and write addresses are independent
  function [15:0] form_ea;
    input [1:0]  mode;
    input [12:0] near;
    input [15:0] direct;
    input [15:0] ptr;
    begin
      case (mode)
        `CMSD_MODE_NEAR:   form_ea = {3'h0, near}; // [R20]
        `CMSD_MODE_DIRECT: form_ea = direct;       // [R21]
        `CMSD_MODE_PTR:    form_ea = ptr;          // [R21]
        default:           form_ea = 16'h0000;
      endcase
    end
  endfunction

  function is_sfr;
    input [15:0] ea;
    begin
      is_sfr = (ea <= `CMSD_SFR_HI); // [R18]
    end
  endfunction

  function is_xram;
    input [15:0] ea;
    begin
      is_xram = (ea >= `CMSD_XRAM_LO) && (ea <= `CMSD_XRAM_HI); // [R22]
    end
  endfunction

  function is_yram;
    input [15:0] ea;
    begin
      is_yram = (ea >= `CMSD_YRAM_LO) && (ea <= `CMSD_YRAM_HI); // [R22]
    end
  endfunction

  function [1:0] vec_class;
    input [23:0] a;
    begin
      if (a >= `CMSD_VEC_END)
        vec_class = `CMSD_VT_NONE; // [R3]
      else if (a >= `CMSD_IVT2_LO && a <= `CMSD_IVT2_HI)
        vec_class = `CMSD_VT_ALT; // [R5]
      else if (a >= `CMSD_IVT1_LO && a <= `CMSD_IVT1_HI)
        vec_class = `CMSD_VT_PRIMARY; // [R5]
      else
        vec_class = `CMSD_VT_RESET; // [R4]
    end
  endfunction

  assign rd_ea = form_ea(i_rd_mode, i_rd_near, i_rd_direct, i_rd_ptr); // [R6] [R7]
  assign wr_ea = form_ea(i_wr_mode, i_wr_near, i_wr_direct, i_wr_ptr); // [R6] [R7]
  assign rd_misalign = i_rd_req & ~i_rd_byte & rd_ea[0]; // [R14]
  assign wr_misalign = i_wr_req & ~i_wr_byte & wr_ea[0]; // [R14]

  // per-lane write enables; a byte write only touches its own lane
  genvar ln;
  generate
    for (ln = 0; ln < 2; ln = ln + 1) begin : g_lane
      assign wr_lane_nxt[ln] = i_wr_req & ~wr_misalign &
                               (~i_wr_byte | (wr_ea[0] == ln)); // [R13] [R15]
      assign wr_data_nxt[ln*8 +: 8] = i_wr_byte ? i_wr_data[7:0]
                                                : i_wr_data[ln*8 +: 8]; // [R10]
    end
  endgenerate

  // boot sequence and program counter
  always @* begin
    state_nxt = state_r;
    pc_nxt    = o_program_counter;
    case (state_r)
      ST_FETCH_JUMP: begin
        state_nxt = ST_FETCH_TGT;
        pc_nxt    = `CMSD_JUMP_TGT; // [R4]
      end
      ST_FETCH_TGT: begin
        state_nxt = ST_RUN;
        pc_nxt    = {i_prog_loc[23:1], 1'b0}; // [R4] [R2]
      end
      ST_RUN: begin
        if (i_pc_load)
          pc_nxt = {i_pc_target[23:1], 1'b0}; // [R2]
        else if (i_pc_adv)
          pc_nxt = o_program_counter + `CMSD_PC_STEP; // [R2]
        else if (i_pc_ret)
          pc_nxt = o_program_counter - `CMSD_PC_STEP; // [R2]
      end
      default: begin
        state_nxt = ST_FETCH_JUMP;
        pc_nxt    = `CMSD_RESET_VEC;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      state_r           <= ST_FETCH_JUMP;
      o_program_counter <= `CMSD_RESET_VEC; // [R3] [R4]
      o_boot_done       <= 1'b0;
      o_pc_vec_table    <= `CMSD_VT_RESET;
      o_tbl_word        <= 16'h0000;
    end else begin
      state_r           <= state_nxt;
      o_program_counter <= pc_nxt;
      o_boot_done       <= (state_nxt == ST_RUN);
      o_pc_vec_table    <= vec_class(pc_nxt);
      // odd address gives the upper word, whose top byte is not there
      o_tbl_word        <= i_tbl_addr[0] ? {8'h00, i_tbl_loc[23:16]}
                                         : i_tbl_loc[15:0]; // [R1]
    end
  end

  // read data assembly, one cycle after the decoded address is out
  always @* begin
    if (o_rd_sel_psv)
      rd_word = i_psv_rdata; // [R8]
    else if (o_rd_sel_xram | o_rd_sel_yram)
      rd_word = i_ram_rdata;
    else if (o_rd_sel_sfr & i_sfr_hit)
      rd_word = i_sfr_rdata;
    else
      rd_word = 16'h0000; // [R9] [R19]
    if (rd_bad_r)
      rd_nxt = 16'h0000; // [R14]
    else if (rd_byte_r)
      rd_nxt = {8'h00, rd_lane_r ? rd_word[15:8] : rd_word[7:0]}; // [R12] [R10]
    else
      rd_nxt = rd_word;
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_rd_word_addr <= 15'h0000;
      o_rd_sel_sfr   <= 1'b0;
      o_rd_sel_xram  <= 1'b0;
      o_rd_sel_yram  <= 1'b0;
      o_rd_sel_psv   <= 1'b0;
      rd_pend_r      <= 1'b0;
      rd_byte_r      <= 1'b0;
      rd_lane_r      <= 1'b0;
      rd_bad_r       <= 1'b0;
      o_rd_data      <= 16'h0000;
      o_rd_valid     <= 1'b0;
    end else begin
      o_rd_word_addr <= rd_ea[15:1]; // [R12]
      o_rd_sel_psv   <= i_rd_req & ~rd_misalign & rd_ea[`CMSD_PSV_BIT]; // [R8]
      o_rd_sel_sfr   <= i_rd_req & ~rd_misalign & is_sfr(rd_ea);
      o_rd_sel_xram  <= i_rd_req & ~rd_misalign & is_xram(rd_ea);
      o_rd_sel_yram  <= i_rd_req & ~rd_misalign & is_yram(rd_ea);
      rd_pend_r      <= i_rd_req;
      rd_byte_r      <= i_rd_byte;
      rd_lane_r      <= rd_ea[0];
      rd_bad_r       <= rd_misalign;
      // a misaligned read still finishes, with zero data
      o_rd_valid     <= rd_pend_r; // [R15]
      o_rd_data      <= rd_pend_r ? rd_nxt : 16'h0000;
    end
  end

  // write path; trap is raised in the same cycle as the suppressed write slot
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_wr_word_addr    <= 15'h0000;
      o_wr_sel_sfr      <= 1'b0;
      o_wr_sel_xram     <= 1'b0;
      o_wr_sel_yram     <= 1'b0;
      o_wr_lane_en      <= 2'h0;
      o_wr_lane_data    <= 16'h0000;
      o_addr_error_trap <= 1'b0;
    end else begin
      o_wr_word_addr    <= wr_ea[15:1]; // [R13]
      o_wr_sel_sfr      <= i_wr_req & ~wr_misalign & is_sfr(wr_ea);
      o_wr_sel_xram     <= i_wr_req & ~wr_misalign & is_xram(wr_ea);
      o_wr_sel_yram     <= i_wr_req & ~wr_misalign & is_yram(wr_ea);
      // writes above the RAM or into the window have nowhere to land
      o_wr_lane_en      <= (is_sfr(wr_ea) | is_xram(wr_ea) | is_yram(wr_ea))
                           ? wr_lane_nxt : 2'h0; // [R13] [R15]
      o_wr_lane_data    <= wr_data_nxt;
      // read trap waits for the read to complete, write trap for the slot
      o_addr_error_trap <= rd_bad_r | wr_misalign; // [R14] [R15]
    end
  end

  // working register merge for loads and extend operations
  always @* begin
    case (i_wreg_op)
      `CMSD_OP_WORD: wreg_nxt = i_wreg_src;
      `CMSD_OP_BYTE: wreg_nxt = {i_wreg_old[15:8], i_wreg_src[7:0]}; // [R16]
      `CMSD_OP_SEXT: wreg_nxt = {{8{i_wreg_old[7]}}, i_wreg_old[7:0]}; // [R17]
      `CMSD_OP_ZEXT: wreg_nxt = {8'h00, i_wreg_old[7:0]}; // [R17]
      default:       wreg_nxt = i_wreg_old;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_ptr_out    <= 16'h0000;
      o_wreg_new   <= 16'h0000;
      o_wreg_valid <= 1'b0;
    end else begin
      if (i_ptr_step) begin
        if (i_ptr_dec)
          o_ptr_out <= i_ptr_in - (i_ptr_byte ? `CMSD_STEP_BYTE : `CMSD_STEP_WORD); // [R11]
        else
          o_ptr_out <= i_ptr_in + (i_ptr_byte ? `CMSD_STEP_BYTE : `CMSD_STEP_WORD); // [R11]
      end
      o_wreg_valid <= i_wreg_op_en;
      if (i_wreg_op_en)
        o_wreg_new <= wreg_nxt;
    end
  end

endmodule // cmsd_top

/* File: sim/cmsd_asserts.sv */
/* port assertions for the memory space decoder.
   assumes synchronous reset and combinational memories at the top. */
module cmsd_asserts (
  input logic        i_clk, i_srst, i_pc_adv, i_pc_load, i_rd_req, i_rd_byte,
  input logic        i_wr_req, i_wr_byte, i_ptr_step, i_ptr_byte, i_ptr_dec,
  input logic        i_wreg_op_en, o_boot_done, o_rd_valid, o_rd_sel_psv,
  input logic        o_addr_error_trap, o_wreg_valid,
  input logic [1:0]  i_rd_mode, i_wr_mode, i_wreg_op, o_wr_lane_en,
  input logic [15:0] i_rd_ptr, i_wr_ptr, i_ptr_in, i_wreg_old, o_rd_data,
  input logic [15:0] o_ptr_out, o_wreg_new,
  input logic [23:0] o_program_counter
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_pc_even: assert property (o_program_counter[0] == 1'b0)
    else $error("program counter odd");
  a_boot_vector: assert property ($fell(i_srst) |=>
    o_program_counter == 24'h000002 ##1 o_boot_done) else $error("boot sequence off");
  a_pc_step: assert property (o_boot_done && i_pc_adv && !i_pc_load |=>
    o_program_counter == $past(o_program_counter) + 24'h000002) else $error("pc step off");
  a_rd_latency: assert property (i_rd_req |-> ##2 o_rd_valid)
    else $error("read result missing");
  a_rd_misalign: assert property (i_rd_req && !i_rd_byte && i_rd_mode == 2'h2 &&
    i_rd_ptr[0] |-> ##1 !o_rd_sel_psv ##1 o_addr_error_trap && o_rd_data == 16'h0000)
    else $error("misaligned read not trapped");
  a_rd_window: assert property (i_rd_req && i_rd_mode == 2'h2 && i_rd_ptr[15] &&
    (i_rd_byte || !i_rd_ptr[0]) |=> o_rd_sel_psv) else $error("window not selected");
  a_wr_misalign: assert property (i_wr_req && !i_wr_byte && i_wr_mode == 2'h2 &&
    i_wr_ptr[0] |=> o_addr_error_trap && o_wr_lane_en == 2'b00)
    else $error("misaligned write not suppressed");
  a_wr_byte_lane: assert property (i_wr_req && i_wr_byte && i_wr_mode == 2'h2 &&
    i_wr_ptr < 16'h1000 |=> o_wr_lane_en == {$past(i_wr_ptr[0]), !$past(i_wr_ptr[0])})
    else $error("byte lane wrong");
  a_ptr_inc: assert property (i_ptr_step && !i_ptr_dec |=> o_ptr_out ==
    $past(i_ptr_in) + ($past(i_ptr_byte) ? 16'h0001 : 16'h0002)) else $error("pointer step");
  a_wreg_byte: assert property (i_wreg_op_en && i_wreg_op == 2'h1 |=> o_wreg_valid &&
    o_wreg_new[15:8] == $past(i_wreg_old[15:8])) else $error("byte load touched high");
endmodule // cmsd_asserts

bind cmsd_top cmsd_asserts i_cmsd_asserts (.*);

/* File: sim/cmsd_mem_model.sv */
/* program memory, ram, register and window model answering at once.
   assumes the decoder presents registered addresses. */
module cmsd_mem_model (
  input  logic [23:0] i_pc,
  input  logic [23:0] i_tbl_addr,
  input  logic [14:0] i_word_addr,
  output logic [23:0] o_prog_loc,
  output logic [23:0] o_tbl_loc,
  output logic [15:0] o_ram_rdata,
  output logic [15:0] o_sfr_rdata,
  output logic        o_sfr_hit,
  output logic [15:0] o_psv_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // odd target on purpose: bit 0 must be dropped
  assign o_prog_loc  = (i_pc == 24'h000002) ? 24'h000241 : {8'hA5, i_pc[15:0]};
  assign o_tbl_loc   = {8'hD7, i_tbl_addr[16:1]};
  assign o_ram_rdata = {1'b0, i_word_addr} ^ 16'h5A3C;
  assign o_sfr_rdata = {1'b1, i_word_addr};
  assign o_sfr_hit   = i_word_addr[3]; // half the register space unused
  assign o_psv_rdata = ~{1'b0, i_word_addr};
endmodule // cmsd_mem_model

/* File: sim/cmsd_top_tb_top.sv */
/* random bench for the memory space decoder against a queue model.
   assumes one 10 MHz clock and combinational memories. */
module cmsd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_srst = 1, i_pc_adv = 0, i_pc_ret = 0, i_pc_load = 0, i_rd_req = 0;
  logic i_rd_byte = 0, i_wr_req = 0, i_wr_byte = 0, i_ptr_step = 0, i_ptr_byte = 0;
  logic i_ptr_dec = 0, i_wreg_op_en = 0, i_sfr_hit, o_boot_done, o_rd_valid, o_wreg_valid;
  logic o_rd_sel_sfr, o_rd_sel_xram, o_rd_sel_yram, o_rd_sel_psv, o_addr_error_trap;
  logic o_wr_sel_sfr, o_wr_sel_xram, o_wr_sel_yram;
  logic [1:0] i_rd_mode = 0, i_wr_mode = 2, i_wreg_op = 0, o_pc_vec_table, o_wr_lane_en;
  logic [12:0] i_rd_near = 0, i_wr_near = 0;
  logic [14:0] o_rd_word_addr, o_wr_word_addr;
  logic [15:0] i_rd_direct = 0, i_rd_ptr = 0, i_wr_direct = 0, i_wr_ptr = 0, i_wr_data = 0;
  logic [15:0] i_ptr_in = 0, i_wreg_old = 0, i_wreg_src = 0, i_ram_rdata, i_sfr_rdata;
  logic [15:0] i_psv_rdata, o_tbl_word, o_rd_data, o_wr_lane_data, o_ptr_out, o_wreg_new;
  logic [23:0] i_pc_target = 0, i_tbl_addr = 0, i_prog_loc, i_tbl_loc, o_program_counter;
  logic [16:0] rq[$];
  logic [15:0] a, d;
  logic b, m;
  int errors = 0, n_checks = 0, cyc = 0;
  cmsd_top i_cmsd_top (.*);
  cmsd_mem_model i_cmsd_mem_model (.i_pc(o_program_counter), .i_tbl_addr(i_tbl_addr),
    .i_word_addr(o_rd_word_addr), .o_prog_loc(i_prog_loc), .o_tbl_loc(i_tbl_loc),
    .o_ram_rdata(i_ram_rdata), .o_sfr_rdata(i_sfr_rdata), .o_sfr_hit(i_sfr_hit),
    .o_psv_rdata(i_psv_rdata));
  initial forever #50 i_clk = ~i_clk;
  task automatic chk(string what, logic [23:0] seen, logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] rd_exp(logic [15:0] ea, logic byt);
    logic [15:0] w;
    if (!byt && ea[0]) return 16'h0000;
    if (ea[15]) w = ~{1'b0, ea[15:1]};
    else if (ea <= 16'h07FF) w = ea[4] ? {1'b1, ea[15:1]} : 16'h0000;
    else if (ea <= 16'h0FFF) w = {1'b0, ea[15:1]} ^ 16'h5A3C;
    else w = 16'h0000;
    return byt ? {8'h00, ea[0] ? w[15:8] : w[7:0]} : w;
  endfunction
  // region selects {window, registers, x ram, y ram}; a refused access selects none
  function automatic logic [3:0] sel_exp(logic [15:0] ea, logic bad);
    if (bad) return 4'h0;
    if (ea[15]) return 4'h8;
    if (ea <= 16'h07FF) return 4'h4;
    if (ea <= 16'h0BFF) return 4'h2;
    return (ea <= 16'h0FFF) ? 4'h1 : 4'h0;
  endfunction
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
    #2;
    if (o_rd_valid === 1'b1) begin
      chk("read data", o_rd_data, rq[0][15:0]);
      chk("read trap", o_addr_error_trap, rq[0][16]);
      void'(rq.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h4653));
    step(5);
    chk("reset pc", o_program_counter, 24'h0);
    chk("reset class", o_pc_vec_table, 2'h1);
    i_srst = 0;
    step(2);
    chk("boot done", o_boot_done, 1'b1);
    chk("boot pc", o_program_counter, 24'h000240);
    i_pc_adv = 1;
    step(3);
    i_pc_adv = 0;
    i_pc_ret = 1;
    step();
    i_pc_ret = 0;
    chk("pc step", o_program_counter, 24'h000244);
    for (int k = 0; k < 3; k++) begin
      i_pc_target = (k == 0) ? 24'h000101 : (k == 1) ? 24'h000011 : 24'h000403;
      i_pc_load = 1;
      step();
      i_pc_load = 0;
      step();
      chk("pc load", o_program_counter, {i_pc_target[23:1], 1'b0});
      chk("pc class", o_pc_vec_table, (k == 0) ? 2'h3 : (k == 1) ? 2'h2 : 2'h0);
    end
    $display("program counter test done");
    for (int k = 0; k < 16; k++) begin
      i_tbl_addr = $urandom & 24'h01FFFF;
      step();
      chk("table", o_tbl_word, i_tbl_addr[0] ? 16'h00D7 : i_tbl_addr[16:1]);
    end
    $display("table test done");
    for (int k = 0; k < 300; k++) begin
      a = (k % 2) ? $urandom : $urandom % 16'h1400;
      b = $urandom;
      i_rd_mode = $urandom;
      i_rd_req = 1;
      i_rd_byte = b;
      i_rd_near = a[12:0];
      i_rd_direct = a;
      i_rd_ptr = a;
      a = (i_rd_mode == 0) ? {3'b000, a[12:0]} : (i_rd_mode == 3) ? 16'h0000 : a;
      rq.push_back({!b && a[0], rd_exp(a, b)});
      step();
      chk("read sel", {o_rd_sel_psv, o_rd_sel_sfr, o_rd_sel_xram, o_rd_sel_yram},
        sel_exp(a, !b && a[0]));
      chk("read addr", o_rd_word_addr, a[15:1]);
    end
    i_rd_req = 0;
    step(4);
    chk("reads pending", rq.size(), 0);
    $display("read test done");
    for (int k = 0; k < 200; k++) begin
      a = (k % 2) ? $urandom : $urandom % 16'h1400;
      d = $urandom;
      b = $urandom;
      i_wr_mode = $urandom;
      i_wr_req = 1;
      i_wr_byte = b;
      i_wr_near = a[12:0];
      i_wr_direct = a;
      i_wr_ptr = a;
      i_wr_data = d;
      a = (i_wr_mode == 0) ? {3'b000, a[12:0]} : (i_wr_mode == 3) ? 16'h0000 : a;
      m = !b && a[0];
      step();
      chk("write trap", o_addr_error_trap, m);
      chk("lanes", o_wr_lane_en, (m || a > 16'h0FFF) ? 0 : !b ? 3 : a[0] ? 2 : 1);
      chk("write sel", {o_wr_sel_sfr, o_wr_sel_xram, o_wr_sel_yram},
        sel_exp(a, m) & 4'h7);
      if (!m && a <= 16'h0FFF) chk("write addr", o_wr_word_addr, a[15:1]);
      chk("lane data", o_wr_lane_data, b ? {d[7:0], d[7:0]} : d);
    end
    i_wr_req = 0;
    $display("write test done");
    for (int k = 0; k < 200; k++) begin
      a = $urandom;
      d = $urandom;
      i_ptr_step = 1;
      i_ptr_in = a;
      i_ptr_byte = $urandom;
      i_ptr_dec = $urandom;
      i_wreg_op_en = 1;
      i_wreg_op = $urandom;
      i_wreg_old = d;
      i_wreg_src = ~a;
      step();
      chk("pointer", o_ptr_out, i_ptr_dec ? 16'(a - 16'h0002 + i_ptr_byte)
        : 16'(a + 16'h0002 - i_ptr_byte));
      chk("wreg", {o_wreg_valid, o_wreg_new}, {1'b1, (i_wreg_op == 0) ? ~a :
        (i_wreg_op == 1) ? {d[15:8], ~a[7:0]} : {i_wreg_op[0] ? 8'h00 : {8{d[7]}}, d[7:0]}});
    end
    i_ptr_step = 0;
    i_wreg_op_en = 0;
    i_ptr_in = ~i_ptr_in;
    d = o_ptr_out;
    step();
    chk("pointer hold", o_ptr_out, d);
    chk("wreg idle", o_wreg_valid, 1'b0);
    $display("pointer and register test done");
    give_verdict();
  end
endmodule // cmsd_top_tb_top
